/* File: rtl/tamlim_cmp.sv */
// one hysteretic over-limit comparator producing a status bit that clears below limit minus hysteresis
module tamlim_cmp (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       sample,
    input  wire logic [7:0] reading,
    input  wire logic [7:0] limit,
    input  wire logic [7:0] hyst,
    output logic            flag
);
    logic [8:0] low_mark;

    // widened so a small limit minus hysteresis clamps at zero, not wraps
    always_comb begin
        low_mark = {1'b0, limit} - {1'b0, hyst};
        if ({1'b0, hyst} > {1'b0, limit}) begin
            low_mark = 9'h000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (sample) begin
            if (reading >= limit) begin
                flag <= 1'b1;
            end else if ({1'b0, reading} < low_mark) begin
                flag <= 1'b0;
            end
        end
    end
endmodule

/* File: rtl/tamlim_gate.sv */
// masks three status bits onto one active-high alarm request
module tamlim_gate (
    input  wire logic [2:0] status,
    input  wire logic [2:0] block,
    output logic            alarm_active
);
    // purely combinational so a mask write acts at once
    always_comb begin
        alarm_active = |(status & ~block);
    end
endmodule

/* File: rtl/tamlim_pkg.sv */
// shared constants and types for the thermal alarm mask and limit bank
package tamlim_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CMD_W  = 8;
    localparam int unsigned NCHAN  = 3;
    localparam int unsigned NPIN   = 3;

    // command bytes
    localparam logic [7:0] CMD_ALARM1_MASK  = 8'h0c;
    localparam logic [7:0] CMD_ALARM2_MASK  = 8'h0d;
    localparam logic [7:0] CMD_ALARM3_MASK  = 8'h0e;
    localparam logic [7:0] CMD_LOCAL_LIMIT  = 8'h40;
    localparam logic [7:0] CMD_REM1_LVL1    = 8'h41;
    localparam logic [7:0] CMD_REM2_LVL1    = 8'h42;
    localparam logic [7:0] CMD_REM1_LVL2    = 8'h49;
    localparam logic [7:0] CMD_REM2_LVL2    = 8'h4a;
    localparam logic [7:0] CMD_HYSTERESIS   = 8'h5a;

    // field layout
    localparam int unsigned BIT_LOCAL   = 0;
    localparam int unsigned BIT_REMOTE1 = 1;
    localparam int unsigned BIT_REMOTE2 = 2;
    localparam logic [7:0] MASK_WMASK   = 8'h07;
    localparam logic [7:0] LOCAL_WMASK  = 8'h7f;
    localparam logic [7:0] REMOTE_WMASK = 8'hff;
    localparam logic [7:0] HYST_WMASK   = 8'h1f;
    localparam logic [7:0] HYST_MAX     = 8'h20;

    // reset values
    localparam logic [7:0] RST_ALARM1_MASK = 8'h01;
    localparam logic [7:0] RST_ALARM2_MASK = 8'h00;
    localparam logic [7:0] RST_ALARM3_MASK = 8'h07;
    localparam logic [7:0] RST_LOCAL_LIMIT = 8'h55;
    localparam logic [7:0] RST_REM_LVL1    = 8'h6e;
    localparam logic [7:0] RST_REM_LVL2    = 8'h55;
    localparam logic [7:0] RST_HYSTERESIS  = 8'h0a;

    // one register access from the bus engine
    typedef struct packed {
        logic       wr_en;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } tamlim_wr_s;

    // integer-degree readings of the three channels
    typedef struct packed {
        logic [7:0] remote2;
        logic [7:0] remote1;
        logic [7:0] local_t;
    } tamlim_temp_s;
endpackage

/* File: rtl/tamlim_top.sv */
// register bank gating thermal error events onto three alarm pins
// How it works
// - mask register 0x0c: bits 2..0 block remote2, remote1, local from pin 1
// - mask register 0x0d: same layout, gates events onto pin 2
// - mask register 0x0e: same layout, gates events onto pin 3
// - mask bit one blocks the channel event; zero lets it through
// - masks reset to 0x01, 0x00 and 0x07
// - mask bits 7..3 read zero whatever is written
// - local limit at 0x40, unsigned 0..127 degrees, resets to 0x55
// - local reading is compared with local limit for the local event
// - local limit bit 7 reads zero; bits 6..0 writable
// - remote limits are fully writable 8-bit unsigned thresholds
// - remote level-1 limits 0x41, 0x42 reset 0x6e, feed pin 1 only
// - remote level-2 limits 0x49, 0x4a reset 0x55, feed pins 2 and 3
// - status sets at reading >= limit, clears below limit minus hysteresis
// - alarm active while any unmasked status bit set
// - one common hysteresis 0..32 degrees lowers every limit
module tamlim_top (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire tamlim_pkg::tamlim_wr_s   reg_wr,
    input  wire logic [7:0]               rd_cmd,
    output logic [7:0]                    rd_data,
    output logic                          rd_hit,
    input  wire logic                     conv_done,
    input  wire tamlim_pkg::tamlim_temp_s temp,
    output logic [2:0]                    status_pin1,
    output logic [2:0]                    status_pin2,
    output logic [2:0]                    status_pin3,
    output logic                          alarm_out_1_n,
    output logic                          alarm_out_2_n,
    output logic                          alarm_out_3_n
);
    logic [2:0] alarm1_source_mask_reg;
    logic [2:0] alarm2_source_mask_reg;
    logic [2:0] alarm3_source_mask_reg;
    logic [6:0] local_over_temp_limit_reg;
    logic [7:0] remote1_first_level_limit_reg;
    logic [7:0] remote2_first_level_limit_reg;
    logic [7:0] remote1_second_level_limit_reg;
    logic [7:0] remote2_second_level_limit_reg;
    logic [5:0] hysteresis_reg;
    logic [7:0] hyst_next;
    logic [7:0] rd_next;
    logic       hit_next;
    logic [2:0] st [3];
    logic [7:0] lim [3][3];
    logic [7:0] rd_val [3];
    logic [2:0] act;

    // mask registers; only bits 2..0 are stored so 7..3 read zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            alarm1_source_mask_reg <= tamlim_pkg::RST_ALARM1_MASK[2:0];
            alarm2_source_mask_reg <= tamlim_pkg::RST_ALARM2_MASK[2:0];
            alarm3_source_mask_reg <= tamlim_pkg::RST_ALARM3_MASK[2:0];
        end else if (reg_wr.wr_en) begin
            unique case (reg_wr.cmd)
                tamlim_pkg::CMD_ALARM1_MASK:
                    alarm1_source_mask_reg <= reg_wr.wdata[2:0];
                tamlim_pkg::CMD_ALARM2_MASK:
                    alarm2_source_mask_reg <= reg_wr.wdata[2:0];
                tamlim_pkg::CMD_ALARM3_MASK:
                    alarm3_source_mask_reg <= reg_wr.wdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // limit registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            local_over_temp_limit_reg      <= tamlim_pkg::RST_LOCAL_LIMIT[6:0];
            remote1_first_level_limit_reg  <= tamlim_pkg::RST_REM_LVL1;
            remote2_first_level_limit_reg  <= tamlim_pkg::RST_REM_LVL1;
            remote1_second_level_limit_reg <= tamlim_pkg::RST_REM_LVL2;
            remote2_second_level_limit_reg <= tamlim_pkg::RST_REM_LVL2;
        end else if (reg_wr.wr_en) begin
            unique case (reg_wr.cmd)
                tamlim_pkg::CMD_LOCAL_LIMIT:
                    local_over_temp_limit_reg <= reg_wr.wdata[6:0];
                tamlim_pkg::CMD_REM1_LVL1:
                    remote1_first_level_limit_reg <= reg_wr.wdata;
                tamlim_pkg::CMD_REM2_LVL1:
                    remote2_first_level_limit_reg <= reg_wr.wdata;
                tamlim_pkg::CMD_REM1_LVL2:
                    remote1_second_level_limit_reg <= reg_wr.wdata;
                tamlim_pkg::CMD_REM2_LVL2:
                    remote2_second_level_limit_reg <= reg_wr.wdata;
                default: begin
                end
            endcase
        end
    end

    // hysteresis: writes above 32 clamp to 32 rather than wrapping
    always_comb begin
        hyst_next = reg_wr.wdata & tamlim_pkg::HYST_WMASK;
        if (reg_wr.wdata > tamlim_pkg::HYST_MAX) begin
            hyst_next = tamlim_pkg::HYST_MAX;
        end
        if (reg_wr.wdata == tamlim_pkg::HYST_MAX) begin
            hyst_next = tamlim_pkg::HYST_MAX;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hysteresis_reg <= tamlim_pkg::RST_HYSTERESIS[5:0];
        end else if (reg_wr.wr_en && reg_wr.cmd == tamlim_pkg::CMD_HYSTERESIS) begin
            hysteresis_reg <= hyst_next[5:0];
        end
    end

    // limit assignment per pin: [pin][channel]
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            lim[p][tamlim_pkg::BIT_LOCAL] = {1'b0, local_over_temp_limit_reg};
        end
        lim[0][tamlim_pkg::BIT_REMOTE1] = remote1_first_level_limit_reg;
        lim[0][tamlim_pkg::BIT_REMOTE2] = remote2_first_level_limit_reg;
        for (int p = 1; p < 3; p++) begin
            lim[p][tamlim_pkg::BIT_REMOTE1] = remote1_second_level_limit_reg;
            lim[p][tamlim_pkg::BIT_REMOTE2] = remote2_second_level_limit_reg;
        end
        rd_val[tamlim_pkg::BIT_LOCAL]   = temp.local_t;
        rd_val[tamlim_pkg::BIT_REMOTE1] = temp.remote1;
        rd_val[tamlim_pkg::BIT_REMOTE2] = temp.remote2;
    end

    // one comparator per pin and channel; pins 2 and 3 share limits but keep
    // separate flags so each pin's status stands on its own
    for (genvar p = 0; p < 3; p++) begin : g_pin
        for (genvar c = 0; c < 3; c++) begin : g_chan
            tamlim_cmp u_cmp (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .sample  (conv_done),
                .reading (rd_val[c]),
                .limit   (lim[p][c]),
                .hyst    ({2'b00, hysteresis_reg}),
                .flag    (st[p][c])
            );
        end
    end

    tamlim_gate u_gate1 (
        .status       (st[0]),
        .block        (alarm1_source_mask_reg),
        .alarm_active (act[0])
    );
    tamlim_gate u_gate2 (
        .status       (st[1]),
        .block        (alarm2_source_mask_reg),
        .alarm_active (act[1])
    );
    tamlim_gate u_gate3 (
        .status       (st[2]),
        .block        (alarm3_source_mask_reg),
        .alarm_active (act[2])
    );

    // pins registered once; a mask write shows one cycle later
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            alarm_out_1_n <= 1'b1;
            alarm_out_2_n <= 1'b1;
            alarm_out_3_n <= 1'b1;
            status_pin1   <= 3'h0;
            status_pin2   <= 3'h0;
            status_pin3   <= 3'h0;
        end else begin
            alarm_out_1_n <= ~act[0];
            alarm_out_2_n <= ~act[1];
            alarm_out_3_n <= ~act[2];
            status_pin1   <= st[0];
            status_pin2   <= st[1];
            status_pin3   <= st[2];
        end
    end

    // read port
    always_comb begin
        rd_next  = 8'h00;
        hit_next = 1'b1;
        unique case (rd_cmd)
            tamlim_pkg::CMD_ALARM1_MASK: rd_next = {5'h00, alarm1_source_mask_reg};
            tamlim_pkg::CMD_ALARM2_MASK: rd_next = {5'h00, alarm2_source_mask_reg};
            tamlim_pkg::CMD_ALARM3_MASK: rd_next = {5'h00, alarm3_source_mask_reg};
            tamlim_pkg::CMD_LOCAL_LIMIT: rd_next = {1'b0, local_over_temp_limit_reg};
            tamlim_pkg::CMD_REM1_LVL1:   rd_next = remote1_first_level_limit_reg;
            tamlim_pkg::CMD_REM2_LVL1:   rd_next = remote2_first_level_limit_reg;
            tamlim_pkg::CMD_REM1_LVL2:   rd_next = remote1_second_level_limit_reg;
            tamlim_pkg::CMD_REM2_LVL2:   rd_next = remote2_second_level_limit_reg;
            tamlim_pkg::CMD_HYSTERESIS:  rd_next = {2'b00, hysteresis_reg};
            default:                     hit_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
            rd_hit  <= 1'b0;
        end else begin
            rd_data <= rd_next;
            rd_hit  <= hit_next;
        end
    end
endmodule

/* File: verif/tamlim_asserts.sv */
// port-level checks for the thermal alarm mask and limit bank
module tamlim_asserts (
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire tamlim_pkg::tamlim_wr_s reg_wr,
    input wire logic [7:0]             rd_cmd,
    input wire logic [7:0]             rd_data,
    input wire logic                   rd_hit,
    input wire logic                   conv_done,
    input wire logic [2:0]             status_pin1,
    input wire logic [2:0]             status_pin2,
    input wire logic [2:0]             status_pin3,
    input wire logic                   alarm_out_1_n,
    input wire logic                   alarm_out_2_n,
    input wire logic                   alarm_out_3_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_mask_rsvd_zero: assert property (
        rd_cmd inside {8'h0c, 8'h0d, 8'h0e} |=> rd_hit && rd_data[7:3] == 5'h00)
        else $error("mask register read shows reserved bits");
    a_local_bit7_zero: assert property (
        rd_cmd == 8'h40 |=> rd_hit && !rd_data[7])
        else $error("local limit read shows bit 7");
    a_remote_limit_hit: assert property (
        rd_cmd inside {8'h41, 8'h42, 8'h49, 8'h4a} |=> rd_hit)
        else $error("remote limit read not recognised");
    a_pin1_has_cause: assert property (
        !alarm_out_1_n |-> status_pin1 != 3'h0)
        else $error("alarm 1 active with no status set");
    a_pin2_has_cause: assert property (
        !alarm_out_2_n |-> status_pin2 != 3'h0)
        else $error("alarm 2 active with no status set");
    a_pin3_has_cause: assert property (
        !alarm_out_3_n |-> status_pin3 != 3'h0)
        else $error("alarm 3 active with no status set");
    a_status_from_conv: assert property (
        $changed({status_pin1, status_pin2, status_pin3}) |-> $past(conv_done, 2))
        else $error("status moved without a conversion");
    // flags and masks both move on the strobe edge; the pin follows one edge later
    a_alarm_needs_cause: assert property (
        !conv_done && !reg_wr.wr_en |-> ##2
            $stable({alarm_out_1_n, alarm_out_2_n, alarm_out_3_n}))
        else $error("alarm moved with no write or conversion");
endmodule

bind tamlim_top tamlim_asserts u_chk (.clk_sys, .rst_n, .reg_wr, .rd_cmd, .rd_data, .rd_hit,
    .conv_done, .status_pin1, .status_pin2, .status_pin3, .alarm_out_1_n, .alarm_out_2_n,
    .alarm_out_3_n);

/* File: verif/tamlim_bench.sv */
// self-checking bench for the thermal alarm mask and limit bank
module tamlim_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] CMDS [9] = '{8'h0c, 8'h0d, 8'h0e, 8'h40, 8'h41, 8'h42, 8'h49,
                                        8'h4a, 8'h5a};
    localparam logic [7:0] RSTV [9] = '{8'h01, 8'h00, 8'h07, 8'h55, 8'h6e, 8'h6e, 8'h55,
                                        8'h55, 8'h0a};
    localparam logic [7:0] FULL [9] = '{8'h07, 8'h07, 8'h07, 8'h7f, 8'hff, 8'hff, 8'hff,
                                        8'hff, 8'h20};
    logic                     clk_sys   = 1'b0;
    logic                     rst_n     = 1'b0;
    logic                     conv_done = 1'b0;
    tamlim_pkg::tamlim_temp_s temp      = '0;
    tamlim_pkg::tamlim_wr_s   reg_wr;
    logic [7:0]               rd_cmd;
    logic [7:0]               rd_data;
    logic                     rd_hit;
    logic [2:0]               status_pin1;
    logic [2:0]               status_pin2;
    logic [2:0]               status_pin3;
    logic                     alarm_out_1_n;
    logic                     alarm_out_2_n;
    logic                     alarm_out_3_n;
    logic [7:0]               d;
    logic                     h;
    int                       errors    = 0;
    int                       n_checks  = 0;

    always #2.5 clk_sys = ~clk_sys;

    tamlim_top u_dut (.clk_sys, .rst_n, .reg_wr, .rd_cmd, .rd_data, .rd_hit, .conv_done,
        .temp, .status_pin1, .status_pin2, .status_pin3, .alarm_out_1_n, .alarm_out_2_n,
        .alarm_out_3_n);
    tamlim_host u_host (.clk_sys, .reg_wr, .rd_cmd, .rd_data, .rd_hit);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // alarm bits given as {pin3, pin2, pin1}, low meaning active
    task automatic look(input logic [2:0] e1, e2, e3, al);
        check({5'h0, status_pin1}, {5'h0, e1});
        check({5'h0, status_pin2}, {5'h0, e2});
        check({5'h0, status_pin3}, {5'h0, e3});
        check({5'h0, alarm_out_3_n, alarm_out_2_n, alarm_out_1_n}, {5'h0, al});
    endtask
    // status and alarms land two edges after the conversion pulse
    task automatic conv(input logic [7:0] r2, r1, lt);
        temp = '{remote2: r2, remote1: r1, local_t: lt};
        conv_done = 1'b1;
        @(negedge clk_sys);
        conv_done = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic reset_and_read();
        rst_n = 1'b0;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        foreach (CMDS[i]) begin
            u_host.rd(CMDS[i], d, h);
            check(d, RSTV[i]);
            check({7'h00, h}, 8'h01);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        reset_and_read();
        conv(8'h00, 8'h6d, 8'h55);
        look(3'b001, 3'b011, 3'b011, 3'b101);
        u_host.wr(8'h0c, 8'h00);
        look(3'b001, 3'b011, 3'b011, 3'b100);
        u_host.wr(8'h0e, 8'h05);
        look(3'b001, 3'b011, 3'b011, 3'b000);
        u_host.wr(8'h0d, 8'h02);
        look(3'b001, 3'b011, 3'b011, 3'b000);
        u_host.wr(8'h0d, 8'h03);
        look(3'b001, 3'b011, 3'b011, 3'b010);
        // at and just above limit minus hysteresis: set flags hold
        conv(8'h6e, 8'h4b, 8'h4c);
        look(3'b101, 3'b111, 3'b111, 3'b000);
        conv(8'h00, 8'h4a, 8'h4a);
        look(3'b000, 3'b000, 3'b000, 3'b111);
        foreach (CMDS[i]) begin
            u_host.wr(CMDS[i], 8'hff);
            u_host.rd(CMDS[i], d, h);
            check(d, FULL[i]);
        end
        u_host.wr(8'h0f, 8'hff);
        u_host.rd(8'h0f, d, h);
        check(d, 8'h00);
        check({7'h00, h}, 8'h00);
        reset_and_read();
        final_report();
    end
endmodule

/* File: verif/tamlim_host.sv */
// management host model: single-byte register writes and reads
module tamlim_host (
    input  wire logic              clk_sys,
    output tamlim_pkg::tamlim_wr_s reg_wr,
    output logic [7:0]             rd_cmd,
    input  wire logic [7:0]        rd_data,
    input  wire logic              rd_hit
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_wr = '0;
        rd_cmd = 8'hff;
    end
    // an idle cycle follows each strobe so back-to-back calls never re-raise it in one step
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        reg_wr = '{wr_en: 1'b1, cmd: cmd, wdata: data};
        @(negedge clk_sys);
        reg_wr.wr_en = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [7:0] data, output logic hit);
        rd_cmd = cmd;
        @(negedge clk_sys);
        data = rd_data;
        hit = rd_hit;
    endtask
endmodule
